/* File: src/dbfc_pkg.sv */
// Package holding register map, field layout and decode types.
package dbfc_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_FUNC_CFG = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_EVENTS   = 8'h08;

  // Field positions in the function configuration register.
  localparam int FUNC_LSB  = 0;
  localparam int MODE0_BIT = 3;
  localparam int MODE1_BIT = 4;
  localparam int END_BIT   = 5;

  localparam logic [7:0] FUNC_CFG_RESET = 8'h20;
  localparam logic [7:0] FUNC_CFG_MASK  = 8'h3f;

  // Function select codes.
  localparam logic [2:0] FN_TIMER    = 3'h0;
  localparam logic [2:0] FN_COUNTER  = 3'h1;
  localparam logic [2:0] FN_CHECKSUM = 3'h2;
  localparam logic [2:0] FN_RSVD3    = 3'h3;
  localparam logic [2:0] FN_DEADTIME = 3'h4;
  localparam logic [2:0] FN_UART     = 3'h5;
  localparam logic [2:0] FN_SPI      = 3'h6;
  localparam logic [2:0] FN_RSVD7    = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Event inputs from the function datapath.
  typedef struct packed {
    logic terminal_count;
    logic compare_value;
    logic compare_equal;
    logic tx_reg_empty;
    logic tx_complete;
    logic rx_reg_full;
    logic spi_complete;
  } dbfc_events_t;

  // Decoded personality driven to the datapath.
  typedef struct packed {
    logic timer_en;
    logic counter_en;
    logic checksum_en;
    logic deadtime_en;
    logic uart_en;
    logic spi_en;
    logic cmp_strict;
    logic uart_tx;
    logic spi_slave;
    logic chain_pass;
    logic chain_end;
  } dbfc_decode_t;

endpackage : dbfc_pkg

/* File: src/dbfc_block.sv */
// Function configuration register and mode decode for one digital block.
// What this block does
// [RQ1] End flag 0: pass chaining signals onward.
// [RQ2] End flag 1: final or standalone block.
// [RQ3] Software never clears end in last block.
// [RQ4] Timer: upper mode picks <= or <.
// [RQ5] Counter: upper mode picks <= or <.
// [RQ6] UART transmit: upper mode picks interrupt source.
// [RQ7] SPI mode1=0: master TX empty, slave RX full.
// [RQ8] SPI slave mode1=1: interrupt on transfer done.
// [RQ9] Timer: lower mode picks terminal or compare.
// [RQ10] Counter: lower mode picks terminal or compare.
// [RQ11] Checksum function ignores both mode bits.
// [RQ12] Dead-time function ignores both mode bits.
// [RQ13] UART: lower mode picks receiver or transmitter.
// [RQ14] SPI: lower mode picks master or slave.
// [RQ15] Function select picks hardware personality.
// [RQ16] Only timer, counter, checksum chain.
// [RQ17] UART code only on communication blocks.
// [RQ18] SPI master mode1=1: interrupt on transfer done.
// [RQ19] SPI only on communication blocks; 111 reserved.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns

module dbfc_block #(
  parameter bit COMM_CAPABLE = 1'b1
) (
  // Clock and reset.
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // AXI4-Lite write address and data.
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response.
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read.
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Datapath events and chaining.
  input  wire dbfc_pkg::dbfc_events_t events,
  input  wire logic                  chain_in,
  output logic                       chain_out,
  // Decoded configuration and selected interrupt.
  output dbfc_pkg::dbfc_decode_t     decode,
  output logic                       block_irq
);

  // Refuses a variant that the decode cannot serve, at elaboration.
  if (COMM_CAPABLE !== 1'b0 && COMM_CAPABLE !== 1'b1) begin : g_bad_param
    $error("COMM_CAPABLE must be 0 or 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function decode.

  function automatic dbfc_pkg::dbfc_decode_t decode_cfg(input logic [7:0] c);
    dbfc_pkg::dbfc_decode_t d;
    logic [2:0]             fn;
    logic                   m0;
    logic                   m1;
    d  = '0;
    fn = c[dbfc_pkg::FUNC_LSB +: 3];
    m0 = c[dbfc_pkg::MODE0_BIT];
    m1 = c[dbfc_pkg::MODE1_BIT];
    case (fn) // see [RQ15]
      dbfc_pkg::FN_TIMER: begin
        d.timer_en   = 1'b1;
        d.cmp_strict = m1; // see [RQ4]
      end
      dbfc_pkg::FN_COUNTER: begin
        d.counter_en = 1'b1;
        d.cmp_strict = m1; // see [RQ5]
      end
      dbfc_pkg::FN_CHECKSUM: begin
        d.checksum_en = 1'b1; // see [RQ11]
      end
      dbfc_pkg::FN_DEADTIME: begin
        d.deadtime_en = 1'b1; // see [RQ12]
      end
      dbfc_pkg::FN_UART: begin
        d.uart_en = COMM_CAPABLE; // see [RQ17]
        d.uart_tx = COMM_CAPABLE & m0; // see [RQ13]
      end
      dbfc_pkg::FN_SPI: begin
        d.spi_en    = COMM_CAPABLE; // see [RQ19]
        d.spi_slave = COMM_CAPABLE & m0; // see [RQ14]
      end
      default: begin
        d = '0; // see [RQ19]
      end
    endcase
    // Only the chainable personalities ever forward to the next block.
    d.chain_end  = c[dbfc_pkg::END_BIT]; // see [RQ2]
    d.chain_pass = ~c[dbfc_pkg::END_BIT] &
                   (d.timer_en | d.counter_en | d.checksum_en); // see [RQ16]
    return d;
  endfunction : decode_cfg

  function automatic logic select_irq(input logic [7:0]             c,
                                      input dbfc_pkg::dbfc_events_t e);
    logic [2:0] fn;
    logic       m0;
    logic       m1;
    logic       cmp;
    logic       r;
    fn  = c[dbfc_pkg::FUNC_LSB +: 3];
    m0  = c[dbfc_pkg::MODE0_BIT];
    m1  = c[dbfc_pkg::MODE1_BIT];
    cmp = m1 ? e.compare_value : (e.compare_value | e.compare_equal);
    case (fn)
      dbfc_pkg::FN_TIMER, dbfc_pkg::FN_COUNTER: begin
        r = m0 ? cmp : e.terminal_count; // see [RQ9] see [RQ10]
      end
      dbfc_pkg::FN_UART: begin
        if (m0) begin
          r = m1 ? e.tx_complete : e.tx_reg_empty; // see [RQ6]
        end else begin
          r = e.rx_reg_full;
        end
        r = r & COMM_CAPABLE;
      end
      dbfc_pkg::FN_SPI: begin
        if (m1) begin
          r = e.spi_complete; // see [RQ8] see [RQ18]
        end else begin
          r = m0 ? e.rx_reg_full : e.tx_reg_empty; // see [RQ7]
        end
        r = r & COMM_CAPABLE;
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction : select_irq

  ////////////////////////////////////////////////////////////////////////////
  // Register and bus state.

  logic [7:0]                 func_cfg;
  logic [7:0]                 next_func_cfg;
  logic [7:0]                 aw_addr;
  logic [7:0]                 next_aw_addr;
  logic                       aw_held;
  logic                       next_aw_held;
  logic [31:0]                w_data;
  logic [31:0]                next_w_data;
  logic [3:0]                 w_strb;
  logic [3:0]                 next_w_strb;
  logic                       w_held;
  logic                       next_w_held;
  logic                       next_bvalid;
  logic [1:0]                 next_bresp;
  logic                       next_rvalid;
  logic [31:0]                next_rdata;
  logic [1:0]                 next_rresp;
  logic [6:0]                 event_seen;
  logic [6:0]                 next_event_seen;
  dbfc_pkg::dbfc_decode_t     next_decode;
  logic                       next_irq;
  logic                       next_chain_out;
  logic                       next_awready;
  logic                       next_wready;
  logic                       next_arready;

  always_comb begin
    next_func_cfg   = func_cfg;
    next_aw_addr    = aw_addr;
    next_aw_held    = aw_held;
    next_w_data     = w_data;
    next_w_strb     = w_strb;
    next_w_held     = w_held;
    next_bvalid     = s_axi_bvalid;
    next_bresp      = s_axi_bresp;
    next_rvalid     = s_axi_rvalid;
    next_rdata      = s_axi_rdata;
    next_rresp      = s_axi_rresp;
    next_event_seen = event_seen | events;

    // Address and data are latched independently, in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_held = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = dbfc_pkg::RESP_OKAY;
      if (aw_addr == dbfc_pkg::ADDR_FUNC_CFG) begin
        if (w_strb[0]) begin
          next_func_cfg = w_data[7:0] & dbfc_pkg::FUNC_CFG_MASK;
        end
      end else if (aw_addr == dbfc_pkg::ADDR_EVENTS) begin
        // Write one to clear; a new event in the same cycle stays set.
        if (w_strb[0]) begin
          next_event_seen = (event_seen & ~w_data[6:0]) | events;
        end
      end else if (aw_addr != dbfc_pkg::ADDR_STATUS) begin
        next_bresp = dbfc_pkg::RESP_SLVERR;
      end
    end

    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = dbfc_pkg::RESP_OKAY;
      next_rdata  = '0;
      case (s_axi_araddr)
        dbfc_pkg::ADDR_FUNC_CFG: next_rdata[7:0] = func_cfg;
        dbfc_pkg::ADDR_STATUS:   next_rdata[10:0] = decode;
        dbfc_pkg::ADDR_EVENTS:   next_rdata[6:0] = event_seen;
        default:                 next_rresp = dbfc_pkg::RESP_SLVERR;
      endcase
    end

    next_decode    = decode_cfg(func_cfg);
    next_irq       = select_irq(func_cfg, events);
    next_chain_out = next_decode.chain_pass & chain_in; // see [RQ1]

    // Ready is offered only while the matching holding slot is free; it is
    // taken from the slot's next state so that it leaves a flip-flop.
    next_awready   = ~next_aw_held;
    next_wready    = ~next_w_held;
    next_arready   = ~next_rvalid;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      func_cfg     <= dbfc_pkg::FUNC_CFG_RESET;
      aw_addr      <= '0;
      aw_held      <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      w_held       <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dbfc_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= dbfc_pkg::RESP_OKAY;
      event_seen   <= '0;
      decode       <= '0;
      block_irq    <= 1'b0;
      chain_out    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      func_cfg     <= next_func_cfg;
      aw_addr      <= next_aw_addr;
      aw_held      <= next_aw_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      w_held       <= next_w_held;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      event_seen   <= next_event_seen;
      decode       <= next_decode;
      block_irq    <= next_irq;
      chain_out    <= next_chain_out;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
    end
  end

endmodule : dbfc_block

/* File: test/dbfc_block_monitor.sv */
// Checker of decode, chaining, interrupt and bus timing of the block.
`timescale 1ns/1ns
module dbfc_block_monitor (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Block side.
  input wire dbfc_pkg::dbfc_events_t events,
  input wire logic chain_in,
  input wire logic chain_out,
  input wire dbfc_pkg::dbfc_decode_t decode,
  input wire logic block_irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_chain_pass: assert property (
    chain_in && decode.chain_pass |=> chain_out || !decode.chain_pass)
    else $error("chain not passed");
  a_chain_stop: assert property (
    !decode.chain_pass |=> !chain_out || decode.chain_pass)
    else $error("chain leaked");
  a_pass_kind: assert property (
    decode.chain_pass |-> !decode.chain_end &&
    (decode.timer_en || decode.counter_en || decode.checksum_en))
    else $error("chain on wrong function");
  a_one_func: assert property ($onehot0({decode.timer_en,
    decode.counter_en, decode.checksum_en, decode.deadtime_en,
    decode.uart_en, decode.spi_en})) else $error("two functions");
  a_quiet_irq: assert property (events == '0 |=> !block_irq)
    else $error("irq without event");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_lat: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("late write response");
endmodule : dbfc_block_monitor
bind dbfc_block dbfc_block_monitor i_dbfc_block_monitor (
  .ref_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .events, .chain_in, .chain_out, .decode, .block_irq
);

/* File: test/dbfc_block_tb.sv */
// Self-checking bench of the digital block function configuration.
`timescale 1ns/1ns
module dbfc_block_tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, chain_in = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, chain_out, block_irq;
  dbfc_pkg::dbfc_events_t events = '0;
  dbfc_pkg::dbfc_decode_t decode;
  int failures = 0, tests_run = 0, cycles = 0;
  dbfc_block i_dbfc_block (
    .ref_clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .events, .chain_in, .chain_out, .decode,
    .block_irq
  );
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, e, input string m);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rdr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rdr(a, d, r);
    chk(d, e, "read data");
    chk({30'h0, r}, 32'h0, "read response");
  endtask : rchk
  task automatic cfg(input logic [7:0] c);
    wr(dbfc_pkg::ADDR_FUNC_CFG, {24'h0, c}, 4'hf, dbfc_pkg::RESP_OKAY);
  endtask : cfg
  task automatic irq_of(input logic [7:0] c, input logic [6:0] ev,
                        output logic [31:0] q);
    cfg(c);
    @(posedge ref_clk);
    events <= dbfc_pkg::dbfc_events_t'(ev);
    repeat (2) @(posedge ref_clk);
    q = {31'h0, block_irq};
    events <= '0;
  endtask : irq_of
  task automatic pass_chk(input logic [7:0] c, input logic e);
    logic [31:0] q;
    cfg(c);
    @(posedge ref_clk);
    chain_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    q = {31'h0, chain_out};
    chain_in <= 1'b0;
    chk(q, {31'h0, e}, "chain out");
  endtask : pass_chk
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(dbfc_pkg::ADDR_FUNC_CFG, 32'h20);
    rchk(dbfc_pkg::ADDR_STATUS, 32'h401);
  endtask : t_reset
  task automatic t_funcs();
    logic [7:0] c [14] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
      8'h27, 8'h2d, 8'h2e, 8'h30, 8'h00, 8'h04, 8'h05};
    logic [10:0] s [14] = '{11'h401, 11'h201, 11'h101, 11'h001, 11'h081,
      11'h041, 11'h021, 11'h001, 11'h049, 11'h025, 11'h411, 11'h402,
      11'h080, 11'h040};
    foreach (c[i]) begin
      cfg(c[i]);
      rchk(dbfc_pkg::ADDR_FUNC_CFG, {24'h0, c[i]});
      rchk(dbfc_pkg::ADDR_STATUS, {21'h0, s[i]});
      chk({21'h0, decode}, {21'h0, s[i]}, "decode port");
    end
    cfg(8'hff);
    rchk(dbfc_pkg::ADDR_FUNC_CFG, 32'h3f);
  endtask : t_funcs
  task automatic t_chain();
    pass_chk(8'h00, 1'b1);
    pass_chk(8'h20, 1'b0);
    pass_chk(8'h02, 1'b1);
    pass_chk(8'h05, 1'b0);
    pass_chk(8'h04, 1'b0);
  endtask : t_chain
  task automatic t_irq();
    logic [15:0] t [23] = '{16'h2081, 16'h2060, 16'h2821, 16'h2880,
      16'h3820, 16'h3841, 16'h2181, 16'h2921, 16'h3920, 16'h2d11, 16'h2d08,
      16'h3d09, 16'h3d10, 16'h2505, 16'h2518, 16'h2611, 16'h2604, 16'h2e05,
      16'h2e10, 16'h3e03, 16'h3603, 16'h23fe, 16'h27fe};
    logic [31:0] q, e;
    foreach (t[i]) begin
      irq_of(t[i][15:8], t[i][7:1], q);
      e = {31'h0, t[i][0]};
      chk(q, e, "irq");
    end
  endtask : t_irq
  task automatic t_ignore();
    logic [31:0] q;
    irq_of(8'h22, 7'h7f, q);
    chk(q, 32'h0, "checksum irq");
    irq_of(8'h3a, 7'h7f, q);
    chk(q, 32'h0, "checksum mode irq");
    rchk(dbfc_pkg::ADDR_STATUS, 32'h101);
    irq_of(8'h24, 7'h7f, q);
    chk(q, 32'h0, "dead-time irq");
    irq_of(8'h3c, 7'h7f, q);
    chk(q, 32'h0, "dead-time mode irq");
    rchk(dbfc_pkg::ADDR_STATUS, 32'h81);
  endtask : t_ignore
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    cfg(8'h21);
    wr(8'h0c, 32'h22, 4'hf, dbfc_pkg::RESP_SLVERR);
    wr(dbfc_pkg::ADDR_FUNC_CFG, 32'h22, 4'h0, dbfc_pkg::RESP_OKAY);
    wr(dbfc_pkg::ADDR_STATUS, 32'h0, 4'hf, dbfc_pkg::RESP_OKAY);
    rchk(dbfc_pkg::ADDR_FUNC_CFG, 32'h21);
    rchk(dbfc_pkg::ADDR_STATUS, 32'h201);
    rdr(8'h0c, d, r);
    chk({30'h0, r}, {30'h0, dbfc_pkg::RESP_SLVERR}, "unmapped read");
    rchk(dbfc_pkg::ADDR_EVENTS, 32'h7f);
    wr(dbfc_pkg::ADDR_EVENTS, 32'h7f, 4'hf, dbfc_pkg::RESP_OKAY);
    rchk(dbfc_pkg::ADDR_EVENTS, 32'h0);
  endtask : t_bus
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_funcs();
    t_chain();
    t_irq();
    t_ignore();
    t_bus();
    close_out();
  end
endmodule : dbfc_block_tb
